// ### core/ref_clock_pll_pkg.sv
// Constants for the sampling-clock source and PLL start control
package ref_clock_pll_pkg;
  // Register offsets, as the host addresses them
  localparam logic [15:0] OFF_SAMPLE_RATE = 16'h4e20;
  localparam logic [15:0] OFF_CLOCK_OUT_EN = 16'h4e8e;
  localparam logic [15:0] OFF_CLOCK_OUT_FREQ = 16'h4e8f;
  localparam logic [15:0] OFF_REFERENCE_FREQ = 16'h4eac;
  localparam logic [15:0] OFF_CLOCK_SOURCE = 16'h4ee8;
  // Clock source selector codes
  localparam logic [31:0] EXT_REFERENCE_PLL_MODE = 32'h0000_0020;
  localparam logic [31:0] BACKPLANE_REFERENCE_PLL_MODE = 32'h0000_0040;
  // Backplane reference, 100 MHz in hertz
  localparam logic [31:0] BACKPLANE_REF_HZ = 32'h05f5_e100;
  // Reset values of the host registers
  localparam logic [31:0] CLOCK_SOURCE_RESET = 32'h0000_0020;
  localparam logic [31:0] REFERENCE_FREQ_RESET = 32'h0098_9680;
  localparam logic [31:0] SAMPLE_RATE_RESET = 32'h03b9_aca0;
  // PLL reference routing toward the PLL mux
  localparam logic [1:0] REF_SEL_NONE = 2'h0;
  localparam logic [1:0] REF_SEL_EXT = 2'h1;
  localparam logic [1:0] REF_SEL_BACKPLANE = 2'h2;
  // Achievable rate granularity: rates snap to multiples of 2**RATE_STEP_LOG2 Hz
  localparam int RATE_STEP_LOG2 = 8;
  localparam logic [31:0] RATE_STEP_MASK = ~((32'h1 << RATE_STEP_LOG2) - 32'h1);
  localparam logic [32:0] RATE_HALF_STEP = 33'h1 << (RATE_STEP_LOG2 - 1);
  // Lock wait times in ms and the clock rate in MHz
  localparam int LOCK_WAIT_MS = 20;
  localparam int LONG_LOCK_WAIT_MS = 200;
  localparam int MCLK_MHZ = 250;
  localparam int LOCK_WAIT_CYCLES = LOCK_WAIT_MS * 1000 * MCLK_MHZ;
  localparam int LONG_LOCK_WAIT_CYCLES = LONG_LOCK_WAIT_MS * 1000 * MCLK_MHZ;
  // Start sequencer states
  typedef enum logic [1:0] {sIdle, sProgram, sWait} start_state_type;
endpackage : ref_clock_pll_pkg

// ### core/ref_clock_pll_select.sv
// Sampling-clock reference selection, PLL programming and lock-wait at card start
`timescale 1ns/100ps
//
// Overview of operation
// - External mode routes external reference into PLL
// - Backplane mode routes backplane reference into PLL
// - Host-written reference frequency drives PLL settings in external mode
// - PLL never bypassed in external mode
// - Start programs PLL; relock only after setting writes, reset or lost lock
// - Lock wait 20 ms, 200 ms for some
// - Failed lock fails start with unlocked error
// - Clock output enable drives or tristates output
// - Output frequency reads synthesized clock frequency
// - Backplane 100 MHz reference, rate from register
// - Source selector writable and reads mode back
// - Rate register reads nearest achievable rate
module ref_clock_pll_select
  import ref_clock_pll_pkg::*;
#(
  parameter int LOCK_WAIT = LOCK_WAIT_CYCLES,
  parameter int LONG_LOCK_WAIT = LONG_LOCK_WAIT_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Host register port
  input wire logic [15:0] regAddr,
  input wire logic regWrite,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  // Card start command and its answer
  input wire logic cardStart,
  output logic startOk,
  output logic pllUnlockedError,
  // PLL side
  input wire logic pllLockRaw,
  output logic [1:0] pllRefSel,
  output logic [31:0] pllRefFreq,
  output logic [31:0] pllTargetRate,
  output logic pllProgram,
  // Clock output buffer and generation gate
  output logic clkOutOe,
  output logic generateEnable
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release and lock input synchronisation
  logic rstMeta;
  logic rstSyncB;
  logic lockMeta;
  logic lockS2;
  logic lockS3;
  logic lockState;

  // Reset enters asynchronously, leaves through two flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta <= 1'b0;
      rstSyncB <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSyncB <= rstMeta;
    end
  end

  // Lock comes from the PLL domain; a change counts once stages two and three agree
  always_ff @(posedge mclk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      lockMeta <= 1'b0;
      lockS2 <= 1'b0;
      lockS3 <= 1'b0;
      lockState <= 1'b0;
    end else begin
      lockMeta <= pllLockRaw;
      lockS2 <= lockMeta;
      lockS3 <= lockS2;
      if (lockS2 == lockS3) begin
        lockState <= lockS3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Host registers
  logic [31:0] clockSourceSelect;
  logic [31:0] referenceFrequency;
  logic [31:0] sampleRateRequest;
  logic clockOutputEnable;
  logic [31:0] clockOutputFrequency;
  logic dirty;

  wire wrSource = regWrite && (regAddr == OFF_CLOCK_SOURCE);
  wire wrRefFreq = regWrite && (regAddr == OFF_REFERENCE_FREQ);
  wire wrRate = regWrite && (regAddr == OFF_SAMPLE_RATE);
  wire wrClkOut = regWrite && (regAddr == OFF_CLOCK_OUT_EN);
  wire clockSettingWrite = wrSource || wrRefFreq || wrRate;

  // Effective reference: backplane is fixed, external is whatever the host says
  wire modeExt = (clockSourceSelect == EXT_REFERENCE_PLL_MODE);
  wire modeBackplane = (clockSourceSelect == BACKPLANE_REFERENCE_PLL_MODE);
  wire [1:0] next_refSel = modeExt ? REF_SEL_EXT :
                           (modeBackplane ? REF_SEL_BACKPLANE : REF_SEL_NONE);
  wire [31:0] next_refFreq = modeBackplane ? BACKPLANE_REF_HZ :
                             referenceFrequency;
  // Snap to the nearest rate the PLL can hit; no bypass path even when rate equals reference
  wire [32:0] rateRounded = {1'b0, sampleRateRequest} + RATE_HALF_STEP;
  wire [31:0] achievedRate = rateRounded[31:0] & RATE_STEP_MASK;
  // A divided-down clock needs the long settle
  wire [31:0] next_waitTarget = (sampleRateRequest < next_refFreq) ? LONG_LOCK_WAIT[31:0] :
                                LOCK_WAIT[31:0];

  // Readback mux; unmapped offsets read zero
  wire [31:0] readMux =
    (regAddr == OFF_CLOCK_SOURCE) ? clockSourceSelect :
    (regAddr == OFF_REFERENCE_FREQ) ? referenceFrequency :
    (regAddr == OFF_SAMPLE_RATE) ? achievedRate :
    (regAddr == OFF_CLOCK_OUT_EN) ? {31'h0, clockOutputEnable} :
    (regAddr == OFF_CLOCK_OUT_FREQ) ? clockOutputFrequency : 32'h0;

  // Register writes; setting changes mark the PLL for relock
  always_ff @(posedge mclk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      clockSourceSelect <= CLOCK_SOURCE_RESET;
      referenceFrequency <= REFERENCE_FREQ_RESET;
      sampleRateRequest <= SAMPLE_RATE_RESET;
      clockOutputEnable <= 1'b0;
      regRdata <= 32'h0;
    end else begin
      if (wrSource) clockSourceSelect <= regWdata;
      if (wrRefFreq) referenceFrequency <= regWdata;
      if (wrRate) sampleRateRequest <= regWdata;
      if (wrClkOut) clockOutputEnable <= regWdata[0];
      regRdata <= readMux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Start sequencer
  start_state_type state;
  start_state_type next_state;
  logic [31:0] waitCount;
  logic [31:0] waitTarget;
  logic running;

  wire waitDone = (state == sWait) && (waitCount >= waitTarget - 32'h1);
  wire quickStart = (state == sIdle) && cardStart && !dirty && lockState;
  wire lockPass = waitDone && lockState;
  wire lockFail = waitDone && !lockState;

  // Next state: only a clock-setting write, a reset or lost lock costs a relock
  always_comb begin
    next_state = state;
    case (state)
      sIdle: begin
        if (cardStart && (dirty || !lockState)) next_state = sProgram;
      end
      sProgram: next_state = sWait;
      sWait: begin
        if (waitDone) next_state = sIdle;
      end
      default: next_state = sIdle;
    endcase
  end

  // Sequencer flops and PLL-facing outputs
  always_ff @(posedge mclk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      state <= sIdle;
      dirty <= 1'b1;
      waitCount <= 32'h0;
      waitTarget <= LOCK_WAIT[31:0];
      running <= 1'b0;
      pllProgram <= 1'b0;
      startOk <= 1'b0;
      pllUnlockedError <= 1'b0;
      pllRefSel <= REF_SEL_NONE;
      pllRefFreq <= REFERENCE_FREQ_RESET;
      pllTargetRate <= SAMPLE_RATE_RESET;
      clockOutputFrequency <= 32'h0;
      clkOutOe <= 1'b0;
      generateEnable <= 1'b0;
    end else begin
      state <= next_state;
      pllRefSel <= next_refSel;
      pllRefFreq <= next_refFreq;
      pllTargetRate <= achievedRate;
      pllProgram <= (state == sIdle) && (next_state == sProgram);
      // A write in the programming cycle keeps the flag set
      if (clockSettingWrite) dirty <= 1'b1;
      else if (state == sProgram) dirty <= 1'b0;
      if (state == sProgram) begin
        waitCount <= 32'h0;
        waitTarget <= next_waitTarget;
      end else if (state == sWait) begin
        waitCount <= waitCount + 32'h1;
      end
      startOk <= quickStart || lockPass;
      pllUnlockedError <= lockFail;
      if (state == sProgram || lockFail || !lockState) running <= 1'b0;
      else if (lockPass || quickStart) running <= 1'b1;
      if (lockPass) clockOutputFrequency <= pllTargetRate;
      clkOutOe <= clockOutputEnable;
      generateEnable <= running && lockState;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  logic checksArmed;

  // Checks start one edge after the internal reset leaves; on the release edge the
  // flops still take their reset branch, so a check started there would misfire
  always_ff @(posedge mclk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      checksArmed <= 1'b0;
    end else begin
      checksArmed <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!checksArmed);

  ext_route_a: assert property (modeExt |=> pllRefSel == REF_SEL_EXT)
    else $error("external mode not routed to PLL");
  bp_route_a: assert property (modeBackplane |=> pllRefSel == REF_SEL_BACKPLANE &&
    pllRefFreq == BACKPLANE_REF_HZ)
    else $error("backplane reference not routed");
  ref_freq_a: assert property (modeExt |=> pllRefFreq == $past(referenceFrequency))
    else $error("PLL reference frequency not host value");
  start_prog_a: assert property (state == sIdle && cardStart && dirty |=> pllProgram ##1
    state == sWait)
    else $error("start with changes did not program PLL");
  no_relock_a: assert property (quickStart |=> startOk && !pllProgram ##1 !pllProgram)
    else $error("relock without setting change");
  wait_hold_a: assert property (state == sWait && !waitDone |=> state == sWait &&
    !startOk && !pllUnlockedError)
    else $error("lock wait cut short");
  lock_fail_a: assert property (lockFail |=> pllUnlockedError && !startOk ##1
    !generateEnable)
    else $error("unlocked PLL did not fail start");
  clk_out_a: assert property (wrClkOut |=> ##1 clkOutOe == $past(regWdata[0], 2))
    else $error("clock output enable not applied");
  gen_gate_a: assert property (generateEnable |-> $past(lockState))
    else $error("generation without PLL lock");
  rate_read_a: assert property (regAddr == OFF_SAMPLE_RATE |=>
    regRdata == $past(achievedRate) && regRdata[RATE_STEP_LOG2-1:0] == '0)
    else $error("rate readback not achievable rate");
  mode_read_a: assert property (regAddr == OFF_CLOCK_SOURCE |=>
    regRdata == $past(clockSourceSelect))
    else $error("mode readback wrong");

  ext_start_c: cover property (modeExt && lockPass);
  bp_start_c: cover property (modeBackplane && lockPass);
  start_fail_c: cover property (lockFail);
  quick_start_c: cover property (quickStart);

endmodule : ref_clock_pll_select

// ### tb/ref_clock_source_model.sv
// Behavioural reference clock source and PLL lock detector facing the block
`timescale 1ns/100ps
module ref_clock_source_model #(
  parameter int LOCK_DELAY = 5
) (
  // Clock
  input wire logic mclk,
  // Reference presence, set by the bench
  input wire logic extPresent,
  input wire logic backplanePresent,
  // PLL control and lock
  input wire logic [1:0] pllRefSel,
  input wire logic pllProgram,
  output logic pllLockRaw
);
  logic refOk;
  int lockCount = 0;
  ////////////////////////////////////////////////////////////////////////
  // Lock needs the selected reference present and gap free
  assign refOk = (pllRefSel == 2'h1) ? extPresent : ((pllRefSel == 2'h2) && backplanePresent);
  // Programming restarts the search; a stale lock shows only in the cycle in which pllProgram is high
  always @(posedge mclk) begin
    if (pllProgram || !refOk)
      lockCount <= 0;
    else if (lockCount < LOCK_DELAY)
      lockCount <= lockCount + 1;
  end
  assign pllLockRaw = refOk && (lockCount == LOCK_DELAY);
endmodule : ref_clock_source_model

// ### tb/ref_clock_pll_select_test.sv
// Self-checking bench for the sampling-clock source and PLL start control
`timescale 1ns/100ps
module ref_clock_pll_select_test
  import ref_clock_pll_pkg::*;
;
  logic mclk, rst_b, regWrite, cardStart, extPresent, backplanePresent, sawProgram;
  logic startOk, pllUnlockedError, pllLockRaw, pllProgram, clkOutOe, generateEnable, ok, err;
  logic [15:0] regAddr;
  logic [31:0] regWdata, regRdata, pllRefFreq, pllTargetRate;
  logic [1:0] pllRefSel;
  int n_errors = 0;
  int checks_done = 0;
  int n;
  ////////////////////////////////////////////////////////////////////////
  // Short lock waits keep the run brief
  ref_clock_pll_select #(.LOCK_WAIT(20), .LONG_LOCK_WAIT(40)) i_ref_clock_pll_select (
    .mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata),
    .regRdata(regRdata), .cardStart(cardStart), .startOk(startOk),
    .pllUnlockedError(pllUnlockedError), .pllLockRaw(pllLockRaw), .pllRefSel(pllRefSel),
    .pllRefFreq(pllRefFreq), .pllTargetRate(pllTargetRate), .pllProgram(pllProgram),
    .clkOutOe(clkOutOe), .generateEnable(generateEnable));
  ref_clock_source_model i_ref_clock_source_model (.mclk(mclk), .extPresent(extPresent),
    .backplanePresent(backplanePresent), .pllRefSel(pllRefSel), .pllProgram(pllProgram),
    .pllLockRaw(pllLockRaw));
  ////////////////////////////////////////////////////////////////////////
  // Compare, access and closing tasks
  task automatic checkWord(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : checkWord
  task automatic checkBit(input logic got, input logic exp, input string what);
    checkWord({31'h0, got}, {31'h0, exp}, what);
  endtask : checkBit
  task automatic writeReg(input logic [15:0] a, input logic [31:0] d);
    @(negedge mclk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge mclk);
    regWrite = 1'b0;
    @(negedge mclk);
  endtask : writeReg
  task automatic checkRead(input logic [15:0] a, input logic [31:0] exp, input string what);
    @(negedge mclk);
    regAddr = a;
    @(negedge mclk);
    checkWord(regRdata, exp, what);
  endtask : checkRead
  // Answer pulses last one cycle, so every falling edge is looked at
  task automatic startCard();
    @(negedge mclk);
    cardStart = 1'b1;
    sawProgram = 1'b0;
    @(negedge mclk);
    cardStart = 1'b0;
    for (n = 0; n < 100; n++) begin
      sawProgram = sawProgram | pllProgram;
      ok = startOk;
      err = pllUnlockedError;
      if (ok | err)
        break;
      @(negedge mclk);
    end
    if (n == 100) begin
      n_errors++;
      $display("mismatch at %0t: no start answer", $time);
      disable tests;
    end
    repeat (2) @(negedge mclk);
  endtask : startCard
  task automatic print_verdict();
    $display("counts: %0d checks, %0d mismatches", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Test sequence; a start that never answers leaves the tests and goes to the verdict
  initial begin
    begin : tests
      rst_b = 1'b0;
      regAddr = OFF_CLOCK_SOURCE;
      regWrite = 1'b0;
      regWdata = 32'h0;
      cardStart = 1'b0;
      extPresent = 1'b1;
      backplanePresent = 1'b1;
      repeat (2) @(negedge mclk);
      rst_b = 1'b1;
      repeat (4) @(negedge mclk);
      checkRead(OFF_CLOCK_SOURCE, EXT_REFERENCE_PLL_MODE, "mode");
      checkRead(OFF_CLOCK_OUT_FREQ, 32'h0, "outfreq");
      checkWord({30'h0, pllRefSel}, {30'h0, REF_SEL_EXT}, "refsel");
      $display("test reset done");
      // Host states a 20 MHz reference; rate snaps to nearest 256 Hz step
      writeReg(OFF_REFERENCE_FREQ, 32'h0131_2d00);
      checkRead(OFF_REFERENCE_FREQ, 32'h0131_2d00, "ref");
      writeReg(OFF_SAMPLE_RATE, 32'h03e2_df80);
      checkRead(OFF_SAMPLE_RATE, 32'h03e2_e000, "rate");
      startCard();
      checkBit(ok & sawProgram, 1'b1, "ext start");
      checkBit(n inside {[19:25]}, 1'b1, "short wait");
      checkWord(pllRefFreq, 32'h0131_2d00, "reffreq");
      checkWord(pllTargetRate, 32'h03e2_e000, "target");
      checkBit(generateEnable, 1'b1, "gen on");
      checkRead(OFF_CLOCK_OUT_FREQ, 32'h03e2_e000, "outfreq");
      startCard();
      checkBit(ok & !sawProgram & (n <= 2), 1'b1, "quick start");
      $display("test ext start done");
      writeReg(OFF_CLOCK_OUT_EN, 32'h1);
      checkBit(clkOutOe, 1'b1, "oe on");
      writeReg(OFF_CLOCK_OUT_EN, 32'h0);
      checkBit(clkOutOe, 1'b0, "oe off");
      writeReg(OFF_CLOCK_OUT_FREQ, 32'h0); // Read-only place, write is dropped
      checkRead(OFF_CLOCK_OUT_FREQ, 32'h03e2_e000, "ro");
      $display("test clock out done");
      // Copy of the reference, an integer multiple, still goes through the PLL
      writeReg(OFF_SAMPLE_RATE, 32'h0131_2d00);
      startCard();
      checkBit(ok & sawProgram & (pllRefSel === REF_SEL_EXT), 1'b1, "no bypass");
      checkRead(OFF_CLOCK_OUT_FREQ, 32'h0131_2d00, "copy freq");
      writeReg(OFF_SAMPLE_RATE, 32'h004c_4b40);
      startCard();
      checkBit(ok & (n inside {[39:45]}), 1'b1, "long wait");
      $display("test wait done");
      // Backplane mode ignores the external input and the reference register
      extPresent = 1'b0;
      writeReg(OFF_CLOCK_SOURCE, BACKPLANE_REFERENCE_PLL_MODE);
      checkRead(OFF_CLOCK_SOURCE, BACKPLANE_REFERENCE_PLL_MODE, "mode");
      startCard();
      checkBit(ok & (pllRefSel === REF_SEL_BACKPLANE), 1'b1, "bp");
      checkWord(pllRefFreq, BACKPLANE_REF_HZ, "bp freq");
      $display("test backplane done");
      writeReg(OFF_CLOCK_SOURCE, EXT_REFERENCE_PLL_MODE);
      startCard();
      checkBit(err & !ok, 1'b1, "unlocked");
      checkBit(generateEnable, 1'b0, "gen off");
      $display("test no reference done");
      // Mid-run reset restores defaults and forces a fresh PLL program
      extPresent = 1'b1;
      writeReg(OFF_CLOCK_OUT_EN, 32'h1);
      rst_b = 1'b0;
      repeat (2) @(negedge mclk);
      rst_b = 1'b1;
      repeat (4) @(negedge mclk);
      checkBit(clkOutOe, 1'b0, "oe reset");
      checkRead(OFF_REFERENCE_FREQ, REFERENCE_FREQ_RESET, "ref reset");
      startCard();
      checkBit(ok & sawProgram, 1'b1, "start after reset");
      $display("test mid reset done");
    end
    print_verdict();
  end
endmodule : ref_clock_pll_select_test
